//--- hw/zol_loop_ctrl.sv
// zero-overhead repeat and multi-instruction loop control with AXI4-Lite registers
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module zol_loop_ctrl #(
    parameter int CNT_BITS = 14
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire zol_pkg::zol_instr_t instr,
    input  wire zol_pkg::zol_exc_t   exc,
    output zol_pkg::zol_ctl_t        ctl,
    output logic                     singleRepeatActive,
    output logic                     multiLoopActive,
    output logic [2:0]               loopNestLevel,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import zol_pkg::*;

    if (CNT_BITS != CNT_W) begin : g_badCnt
        $error("CNT_BITS must equal the 14-bit counter width");
    end

    logic [CNT_W-1:0] repeatCounter_q;
    logic             singleRepeat_q;
    logic             psvFirst_q;
    logic             stall_q;
    logic             expectOperand_q;
    logic [21:0]      loopStart_q;
    logic [21:0]      loopEnd_q;
    logic [CNT_W-1:0] loopCount_q;
    logic [21:0]      shadowStart_q;
    logic [21:0]      shadowEnd_q;
    logic [CNT_W-1:0] shadowCount_q;
    logic [2:0]       nestLevel_q;

    logic [7:0]       awAddr_q;
    logic             awHeld_q;
    logic [31:0]      wData_q;
    logic [3:0]       wStrb_q;
    logic             wHeld_q;
    logic             bValid_q;
    logic [1:0]       bResp_q;
    logic             rValid_q;
    logic [31:0]      rData_q;
    logic [1:0]       rResp_q;

    logic             wrFire;
    logic [31:0]      wrMerged;
    logic             stallNow;
    logic             executes;
    logic             targetExec;
    logic             loopMatch;
    logic             loopBranch;
    logic             loopEndNow;
    logic             psvSlow;

    // register readback, shared by reads and byte-lane merging
    function automatic logic [31:0] regRead(input logic [7:0] addr);
        logic [31:0] v;
        v = '0;
        case (addr)
            OFF_REPEAT_COUNT: v[CNT_W-1:0] = repeatCounter_q;
            OFF_LOOP_START:   v[ADDR_STORE_MSB:ADDR_STORE_LSB] = loopStart_q;
            OFF_LOOP_END:     v[ADDR_STORE_MSB:ADDR_STORE_LSB] = loopEnd_q;
            OFF_LOOP_COUNT:   v[CNT_W-1:0] = loopCount_q;
            OFF_STATUS: begin
                v[BIT_SINGLE_REPEAT] = singleRepeat_q;
                v[BIT_MULTI_LOOP]    = |nestLevel_q;
            end
            OFF_CORE_CONFIG:  v[NEST_LSB+2:NEST_LSB] = nestLevel_q;
            default:          v = '0;
        endcase
        return v;
    endfunction : regRead

    function automatic logic mapped(input logic [7:0] addr);
        return addr == OFF_REPEAT_COUNT || addr == OFF_LOOP_START || addr == OFF_LOOP_END
            || addr == OFF_LOOP_COUNT || addr == OFF_STATUS || addr == OFF_CORE_CONFIG;
    endfunction : mapped

    // ---------------- AXI4-Lite slave ----------------
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign wrFire        = awHeld_q && wHeld_q && !bValid_q;

    always_comb begin
        wrMerged = regRead(awAddr_q);
        for (int b = 0; b < 4; b++) begin
            if (wStrb_q[b]) begin
                wrMerged[b*8 +: 8] = wData_q[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
        end else if (wrFire) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (wrFire) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else if (wrFire) begin
            bValid_q <= 1'b1;
            bResp_q  <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rValid_q <= 1'b0;
            rData_q  <= 32'h0000_0000;
            rResp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rData_q  <= regRead({s_axi_araddr[7:2], 2'h0});
            rResp_q  <= mapped({s_axi_araddr[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // ---------------- pipeline effects ----------------
    // psv slow path
    assign psvSlow    = psvFirst_q && singleRepeat_q && instr.psvRead;
    assign stallNow   = instr.valid && (instr.xDep || psvSlow) && !stall_q;
    assign executes   = instr.valid && !stallNow;
    assign targetExec = executes && singleRepeat_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stall_q <= 1'b0;
        end else begin
            stall_q <= stallNow;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expectOperand_q <= 1'b0;
        end else if (executes) begin
            expectOperand_q <= instr.twoWord && !instr.secondWord;
        end
    end

    // ---------------- single-instruction repeat ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            repeatCounter_q <= '0;
        end else if (executes && instr.repeatOp) begin
            repeatCounter_q <= instr.count[CNT_W-1:0];
        end else if (targetExec && repeatCounter_q != '0) begin
            repeatCounter_q <= repeatCounter_q - 1'b1;
        end else if (wrFire && awAddr_q == OFF_REPEAT_COUNT) begin
            repeatCounter_q <= wrMerged[CNT_W-1:0];
        end
    end

    // software writes to status never reach this flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            singleRepeat_q <= 1'b0;
        end else if (exc.excEntry) begin
            singleRepeat_q <= 1'b0;
        end else if (exc.srlPop) begin
            singleRepeat_q <= exc.poppedRa;
        end else if (executes && instr.repeatOp) begin
            singleRepeat_q <= instr.count[CNT_W-1:0] != '0;
        end else if (targetExec && repeatCounter_q <= 14'h0001) begin
            singleRepeat_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            psvFirst_q <= 1'b0;
        end else if (exc.srlPop) begin
            psvFirst_q <= exc.poppedRa;
        end else if (targetExec) begin
            psvFirst_q <= 1'b0;
        end
    end

    // ---------------- multi-instruction loop ----------------
    // compare at end-address prefetch
    assign loopMatch  = multiLoopActive && instr.fetchValid
                     && instr.fetchPc[ADDR_STORE_MSB:ADDR_STORE_LSB] == loopEnd_q;
    assign loopBranch = loopMatch && loopCount_q != '0;
    assign loopEndNow = loopMatch && loopCount_q == '0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loopStart_q   <= '0;
            loopEnd_q     <= '0;
            loopCount_q   <= '0;
            shadowStart_q <= '0;
            shadowEnd_q   <= '0;
            shadowCount_q <= '0;
        end else if (executes && instr.doOp) begin
            if (nestLevel_q != NEST_NONE) begin
                shadowStart_q <= loopStart_q;
                shadowEnd_q   <= loopEnd_q;
                shadowCount_q <= loopCount_q;
            end
            loopStart_q <= instr.startAddr[ADDR_STORE_MSB:ADDR_STORE_LSB];
            loopEnd_q   <= instr.endAddr[ADDR_STORE_MSB:ADDR_STORE_LSB];
            loopCount_q <= instr.count[CNT_W-1:0];
        end else if (loopBranch) begin
            loopCount_q <= loopCount_q - 1'b1;
        end else if (loopEndNow && nestLevel_q == NEST_TWO) begin
            loopStart_q <= shadowStart_q;
            loopEnd_q   <= shadowEnd_q;
            loopCount_q <= shadowCount_q;
        end else if (wrFire) begin
            case (awAddr_q)
                OFF_LOOP_START: loopStart_q <= wrMerged[ADDR_STORE_MSB:ADDR_STORE_LSB];
                OFF_LOOP_END:   loopEnd_q   <= wrMerged[ADDR_STORE_MSB:ADDR_STORE_LSB];
                OFF_LOOP_COUNT: loopCount_q <= wrMerged[CNT_W-1:0];
                default:        loopCount_q <= loopCount_q;
            endcase
        end
    end

    // deeper levels only count; their registers are software's to save
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nestLevel_q <= NEST_NONE;
        end else if (executes && instr.doOp) begin
            if (nestLevel_q != NEST_MAX) begin
                nestLevel_q <= nestLevel_q + 1'b1;
            end
        end else if (loopEndNow) begin
            nestLevel_q <= nestLevel_q - 1'b1;
        end
    end

    assign multiLoopActive    = |nestLevel_q;
    assign loopNestLevel      = nestLevel_q;
    assign singleRepeatActive = singleRepeat_q;

    // ---------------- control outputs ----------------
    always_comb begin
        ctl                = '0;
        ctl.pcHold         = singleRepeat_q || stallNow;
        ctl.pcLoad         = loopBranch;
        ctl.pcTarget       = {1'b0, loopStart_q, 1'b0};
        ctl.stall          = stallNow;
        ctl.execNop        = instr.valid && instr.secondWord && !expectOperand_q;
        ctl.operandFetch   = executes && instr.twoWord && !instr.secondWord;
        ctl.stackedRa      = singleRepeat_q;
        ctl.prefetchRepeat = exc.retCycle3 && singleRepeat_q;
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    repeat_load_a: assert property (executes && instr.repeatOp && !exc.excEntry && !exc.srlPop
        && instr.count[13:0] != 14'h0000 |=> singleRepeat_q
        && repeatCounter_q == $past(instr.count[13:0]))
        else $error("repeat load did not set flag and count");
    repeat_zero_a: assert property (executes && instr.repeatOp && !exc.srlPop
        && instr.count[13:0] == 14'h0000 |=> !singleRepeat_q)
        else $error("zero repeat count set the flag");
    repeat_hold_a: assert property (targetExec && repeatCounter_q != 14'h0000
        && !exc.excEntry && !exc.srlPop |-> ctl.pcHold ##1 singleRepeat_q == |repeatCounter_q
        && repeatCounter_q == $past(repeatCounter_q) - 14'h0001)
        else $error("repeat did not hold pc and decrement");
    exc_clear_a: assert property (exc.excEntry |-> ctl.stackedRa == singleRepeat_q
        ##1 !singleRepeat_q)
        else $error("exception entry did not stack and clear flag");
    ret_restore_a: assert property (exc.srlPop && !exc.excEntry
        |=> singleRepeat_q == $past(exc.poppedRa))
        else $error("popped flag not restored");
    psv_first_a: assert property (psvFirst_q && singleRepeat_q && instr.valid
        && instr.psvRead && !stall_q |-> ctl.stall ##1 !ctl.stall)
        else $error("first program space target pass not stalled");
    dep_stall_a: assert property (instr.valid && instr.xDep && !stall_q
        |-> ctl.stall ##1 !ctl.stall)
        else $error("dependency stall not exactly one cycle");
    orphan_nop_a: assert property (instr.valid && instr.secondWord && !expectOperand_q
        |-> ctl.execNop)
        else $error("orphan second word not executed as nop");
    operand_pair_a: assert property (executes && instr.twoWord && !instr.secondWord
        |-> ctl.operandFetch ##1 !ctl.execNop) else $error("operand word ran as nop");
    do_first_a: assert property (executes && instr.doOp && nestLevel_q == 3'h0
        |=> nestLevel_q == 3'h1 && multiLoopActive)
        else $error("first loop did not set level one");
    nest_shadow_a: assert property (executes && instr.doOp && nestLevel_q == 3'h1
        |=> nestLevel_q == 3'h2 && shadowStart_q == $past(loopStart_q)
        && shadowCount_q == $past(loopCount_q))
        else $error("nested loop did not shadow registers");
    loop_branch_a: assert property (loopBranch && !(executes && instr.doOp)
        |-> ctl.pcLoad ##1 loopCount_q == $past(loopCount_q) - 14'h0001)
        else $error("loop end match did not branch and decrement");
    inner_end_a: assert property (loopEndNow && nestLevel_q == 3'h2
        && !(executes && instr.doOp) |=> nestLevel_q == 3'h1 && multiLoopActive
        && loopStart_q == $past(shadowStart_q))
        else $error("inner loop end did not restore outer loop");
    outer_end_a: assert property (loopEndNow && nestLevel_q == 3'h1
        && !(executes && instr.doOp) |=> !multiLoopActive)
        else $error("outer loop end left flag set");

    repeat_run_c: cover property (executes && instr.repeatOp ##1 singleRepeat_q [*3]
        ##1 !singleRepeat_q);
    nest_run_c:   cover property (nestLevel_q == 3'h2 ##[1:50] nestLevel_q == 3'h0);
    exc_resume_c: cover property (exc.excEntry ##[1:40] exc.srlPop && exc.poppedRa);
endmodule : zol_loop_ctrl

//--- hw/zol_pkg.sv
// shared constants and carrier types for the zero-overhead loop controller
package zol_pkg;
    localparam int PC_W  = 24;
    localparam int CNT_W = 14;

    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_REPEAT_COUNT = 8'h00;
    localparam logic [7:0] OFF_LOOP_START   = 8'h04;
    localparam logic [7:0] OFF_LOOP_END     = 8'h08;
    localparam logic [7:0] OFF_LOOP_COUNT   = 8'h0C;
    localparam logic [7:0] OFF_STATUS       = 8'h10;
    localparam logic [7:0] OFF_CORE_CONFIG  = 8'h14;

    // field positions
    localparam int BIT_SINGLE_REPEAT = 4;
    localparam int BIT_MULTI_LOOP    = 9;
    localparam int NEST_LSB          = 8;
    localparam int ADDR_STORE_MSB    = 22;
    localparam int ADDR_STORE_LSB    = 1;

    localparam logic [2:0] NEST_NONE = 3'h0;
    localparam logic [2:0] NEST_ONE  = 3'h1;
    localparam logic [2:0] NEST_TWO  = 3'h2;
    localparam logic [2:0] NEST_MAX  = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one instruction cycle as seen by the loop hardware
    typedef struct packed {
        logic            valid;      // an instruction executes this cycle
        logic            twoWord;    // first word of a two-word instruction
        logic            secondWord; // fetched word is a second (operand) word
        logic            xDep;       // X read/write address dependency
        logic            psvRead;    // operand read through program_space_window
        logic            repeatOp;   // single-instruction repeat
        logic            doOp;       // multi-instruction loop
        logic [15:0]     count;      // literal or working register value
        logic [PC_W-1:0] startAddr;  // first loop instruction
        logic [PC_W-1:0] endAddr;    // last loop instruction
        logic            fetchValid; // a prefetch happens this cycle
        logic [PC_W-1:0] fetchPc;    // address being prefetched
    } zol_instr_t;

    typedef struct packed {
        logic excEntry;  // exception entry, status_low_byte stacked now
        logic srlPop;    // interrupt_return pops status_low_byte now
        logic poppedRa;  // single_repeat_active bit of the popped byte
        logic retCycle3; // third cycle of interrupt_return
    } zol_exc_t;

    typedef struct packed {
        logic            pcHold;         // do not advance the program counter
        logic            pcLoad;         // load pcTarget into the program counter
        logic [PC_W-1:0] pcTarget;
        logic            stall;          // insert one idle cycle
        logic            execNop;        // execute current word as no-operation
        logic            operandFetch;   // next fetch carries operand data
        logic            stackedRa;      // value to stack in status_low_byte
        logic            prefetchRepeat; // prefetch the repeated instruction
    } zol_ctl_t;
endpackage : zol_pkg

//--- tb/zero_overhead_loop_control_tb.sv
// self-checking bench for the zero-overhead loop controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module zero_overhead_loop_control_tb;
    import zol_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    zol_instr_t  ins = '0;
    zol_exc_t    ex = '0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, rData;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp;
    logic [33:0] expQ[$];
    string       nameQ[$];
    int          n_fail = 0, num_checks = 0, cycles = 0;
    integer      seed = 32'hbb78;
    logic [31:0] rv;
    logic [33:0] expV;
    string       nmV;
    zol_instr_t  ti;

    always #5 clk = ~clk;

    zol_loop_ctrl dut (.clk(clk), .rst_n(rst_n), .instr(ins), .exc(ex), .ctl(),
        .singleRepeatActive(), .multiLoopActive(), .loopNestLevel(),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    // oldest note is matched to each response as it appears
    always @(posedge clk) begin
        if ((rValid && rReady) || (bValid && bReady)) begin
            if (expQ.size() == 0) begin
                `CHK("unexpected response", 1'b0, 1'b1)
            end else begin
                // pop once, so the note and its name stay paired
                nmV = nameQ.pop_front();
                expV = expQ.pop_front();
                if (rValid) `CHK(nmV, expV, {rResp, rData})
                else `CHK(nmV, expV, {bResp, 32'h0})
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, 32'h0});
        nameQ.push_back($sformatf("bresp@%h", a));
        @(posedge clk);
        awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
        do @(negedge clk); while (!(awReady && wReady));
        @(posedge clk);
        awValid <= 1'b0; wValid <= 1'b0;
        do @(negedge clk); while (!bValid);
        @(posedge clk);
        bReady <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, d});
        nameQ.push_back($sformatf("read@%h", a));
        @(posedge clk);
        arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
        do @(negedge clk); while (!arReady);
        @(posedge clk);
        arValid <= 1'b0;
        do @(negedge clk); while (!rValid);
        @(posedge clk);
        rReady <= 1'b0;
    endtask : rd

    // one instruction cycle on the core side; the inputs then hold until the next raw drive
    task automatic step(input logic v, input logic rep, input logic dop, input logic [15:0] c,
                        input logic [23:0] s, input logic [23:0] e, input logic fv,
                        input logic [23:0] fpc, input zol_exc_t x);
        zol_instr_t t;
        t = '0;
        t.valid = v; t.repeatOp = rep; t.doOp = dop; t.count = c;
        t.startAddr = s; t.endAddr = e; t.fetchValid = fv; t.fetchPc = fpc;
        raw(t, x);
    endtask : step

    // whole-struct drive, so each input changes once per edge
    task automatic raw(input zol_instr_t i, input zol_exc_t x);
        @(posedge clk);
        ins <= i;
        ex <= x;
    endtask : raw

    task automatic idle();
        step(1'b0, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, '0);
    endtask : idle

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        rv = $random(seed);
        wr(OFF_REPEAT_COUNT, rv, RESP_OKAY);
        rd(OFF_REPEAT_COUNT, rv & 32'h3FFF, RESP_OKAY);
        // bit zero and top bit dropped
        wr(OFF_LOOP_START, 32'hFFFFFF, RESP_OKAY);
        rd(OFF_LOOP_START, 32'h7FFFFE, RESP_OKAY);
        wr(OFF_STATUS, 32'h210, RESP_OKAY);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        $display("register test done");
        step(1'b1, 1'b1, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        step(1'b1, 1'b1, 1'b0, 16'h2, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_STATUS, 32'h10, RESP_OKAY);
        rd(OFF_REPEAT_COUNT, 32'h2, RESP_OKAY);
        step(1'b0, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, 4'b1000);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        step(1'b0, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, 4'b0110);
        idle();
        rd(OFF_STATUS, 32'h10, RESP_OKAY);
        repeat (3) step(1'b1, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_REPEAT_COUNT, 32'h0, RESP_OKAY);
        // handler clears the count, loop ends after return
        step(1'b1, 1'b1, 1'b0, 16'h5, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        step(1'b0, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, 4'b1000);
        idle();
        wr(OFF_REPEAT_COUNT, 32'h0, RESP_OKAY);
        step(1'b0, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, 4'b0110);
        repeat (2) step(1'b1, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        $display("repeat test done");
        rv = $random(seed);
        step(1'b1, 1'b0, 1'b1, {rv[15:14], 14'h1}, 24'h100, 24'h108, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_LOOP_COUNT, 32'h1, RESP_OKAY);
        rd(OFF_LOOP_END, 32'h108, RESP_OKAY);
        rd(OFF_CORE_CONFIG, 32'h100, RESP_OKAY);
        rd(OFF_STATUS, 32'h200, RESP_OKAY);
        step(1'b1, 1'b0, 1'b1, 16'h0, 24'h200, 24'h204, 1'b0, 24'h0, '0);
        idle();
        rd(OFF_CORE_CONFIG, 32'h200, RESP_OKAY);
        rd(OFF_STATUS, 32'h200, RESP_OKAY);
        step(1'b1, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b1, 24'h204, '0);
        idle();
        rd(OFF_CORE_CONFIG, 32'h100, RESP_OKAY);
        rd(OFF_LOOP_START, 32'h100, RESP_OKAY);
        step(1'b1, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b1, 24'h108, '0);
        idle();
        rd(OFF_LOOP_COUNT, 32'h0, RESP_OKAY);
        rd(OFF_STATUS, 32'h200, RESP_OKAY);
        step(1'b1, 1'b0, 1'b0, 16'h0, 24'h0, 24'h0, 1'b1, 24'h108, '0);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_CORE_CONFIG, 32'h0, RESP_OKAY);
        $display("loop test done");
        // dependency stall, instruction held for its retry
        ti = '0; ti.valid = 1'b1; ti.xDep = 1'b1;
        repeat (2) raw(ti, '0);
        // orphan second word, then a proper pair
        ti = '0; ti.valid = 1'b1; ti.secondWord = 1'b1;
        raw(ti, '0);
        ti.secondWord = 1'b0; ti.twoWord = 1'b1;
        raw(ti, '0);
        ti.twoWord = 1'b0; ti.secondWord = 1'b1;
        raw(ti, '0);
        // resumed repeat of a program_space_window target
        step(1'b1, 1'b1, 1'b0, 16'h1, 24'h0, 24'h0, 1'b0, 24'h0, '0);
        raw('0, 4'b1000);
        raw('0, 4'b0110);
        raw('0, 4'b0001);
        ti = '0; ti.valid = 1'b1; ti.psvRead = 1'b1;
        repeat (3) raw(ti, '0);
        idle();
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_REPEAT_COUNT, 32'h0, RESP_OKAY);
        $display("pipeline test done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule : zero_overhead_loop_control_tb
